// file: logic/expander_defines.vh
// Constants shared by the port expander design files.
`ifndef EXPANDER_DEFINES_VH
`define EXPANDER_DEFINES_VH

// ****************************************************************
// Register selection by the low two bits of the command byte
// ****************************************************************
`define SEL_INPUT       2'h0
`define SEL_OUTPUT      2'h1
`define SEL_POLARITY    2'h2
`define SEL_DIRECTION   2'h3

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_OUTPUT      8'hff
`define RST_POLARITY    8'h00
`define RST_DIRECTION   8'hff
`define RST_SELECT      2'h0

// ****************************************************************
// Slave address: fixed upper bits, the pins fill the low three
// ****************************************************************
`define ADDR_UPPER      4'h4

// ****************************************************************
// Timing counts
// ****************************************************************
`define BYTE_BITS       4'h8
// The settle count must outlast the pin filter's fill after reset.
`define SETTLE_CYCLES   3'h5

`endif

// file: logic/pin_sync.v
// Three-stage synchroniser with agreement filter for pins from outside the clock domain.
module pin_sync #(
    parameter             WIDTH = 1,
    parameter [WIDTH-1:0] INIT  = {WIDTH{1'b0}}
)
(
    // Clock and reset
    input  wire             core_clk,
    input  wire             sys_rst,
    // Raw pins and filtered levels
    input  wire [WIDTH-1:0] pin_raw,
    output wire [WIDTH-1:0] pin_level
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            reg stage1;
            reg stage2;
            reg stage3;
            reg stable;
            always @(posedge core_clk)
            begin
                if (sys_rst)
                begin
                    stage1 <= INIT[i];
                    stage2 <= INIT[i];
                    stage3 <= INIT[i];
                    stable <= INIT[i];
                end
                else
                begin
                    stage1 <= pin_raw[i];
                    stage2 <= stage1;
                    stage3 <= stage2;
                    // A change counts only once two stages agree.
                    if (stage2 == stage3)
                    begin
                        stable <= stage3;
                    end
                end
            end
            assign pin_level[i] = stable;
        end
    endgenerate

endmodule

// file: logic/alert_logic.v
// Input change detector that raises and clears the alert level.
`include "expander_defines.vh"

module alert_logic (
    // Clock and reset
    input  wire       core_clk,
    input  wire       sys_rst,
    // Port state
    input  wire [7:0] port_level,
    input  wire [7:0] input_mode,
    // Clear request from the bus side
    input  wire       clear_req,
    // Alert level, high while a change is pending
    output reg        alert
);

    reg  [7:0] snapshot;
    reg  [2:0] settle;
    reg  [7:0] next_snapshot;
    wire       settled;

    assign settled = (settle == `SETTLE_CYCLES);

    // The snapshot follows the pins until the synchroniser has filled,
    // so that reset does not leave a false alert behind.
    always @*
    begin
        next_snapshot = snapshot;
        if (!settled || clear_req)
        begin
            next_snapshot = port_level;
        end
    end

    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            snapshot <= 8'h00;
            settle   <= 3'h0;
            alert    <= 1'b0;
        end
        else
        begin
            if (!settled)
            begin
                settle <= settle + 3'h1;
            end
            snapshot <= next_snapshot;
            // Output pins are masked out; a pin that turns into an input
            // with a level unlike the snapshot alerts at once.
            alert <= settled & (|((port_level ^ next_snapshot) & input_mode));
        end
    end

endmodule

// file: logic/port_expander.v
// Eight-bit serial-bus port expander: slave transactions, registers and alert.
`include "expander_defines.vh"

module port_expander (
    // Clock and reset
    input  wire       core_clk,
    input  wire       sys_rst,
    // Serial bus
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output reg        sda_oe,
    // Address select pins
    input  wire       addr_select_bit0,
    input  wire       addr_select_bit1,
    input  wire       addr_select_bit2,
    // Port pins
    input  wire [7:0] port_in,
    output reg  [7:0] port_out,
    output reg  [7:0] port_oe,
    // Open-drain alert, active low
    output wire       alert_n_out,
    output wire       alert_n_oe
);

    // ****************************************************************
    // States
    // ****************************************************************
    localparam [8:0] ST_IDLE      = 9'h001;
    localparam [8:0] ST_ADDR      = 9'h002;
    localparam [8:0] ST_ADDR_ACK  = 9'h004;
    localparam [8:0] ST_CMD       = 9'h008;
    localparam [8:0] ST_CMD_ACK   = 9'h010;
    localparam [8:0] ST_WDATA     = 9'h020;
    localparam [8:0] ST_WDATA_ACK = 9'h040;
    localparam [8:0] ST_RDATA     = 9'h080;
    localparam [8:0] ST_RDATA_ACK = 9'h100;

    // ****************************************************************
    // Signals
    // ****************************************************************
    wire [1:0] bus_level;
    wire [10:0] pin_level;
    wire       scl_s;
    wire       sda_s;
    wire [7:0] port_s;
    wire [2:0] addr_pins;
    reg        scl_q;
    reg        sda_q;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_seen;
    wire       stop_seen;
    reg  [8:0] state;
    reg  [3:0] bit_count;
    reg  [7:0] rx_shift;
    reg  [7:0] tx_shift;
    reg        read_mode;
    reg        addressed;
    reg        master_ack;
    reg  [1:0] reg_select;
    reg  [7:0] polarity;
    reg        alert_clear;
    wire       alert;
    wire       addr_match;

    // ****************************************************************
    // Register read selection
    // ****************************************************************
    function [7:0] read_value;
        input [1:0] sel;
        input [7:0] pins;
        input [7:0] outs;
        input [7:0] pol;
        input [7:0] dirs;
        begin
            case (sel)
                `SEL_INPUT:     read_value = pins ^ pol;
                `SEL_OUTPUT:    read_value = outs;
                `SEL_POLARITY:  read_value = pol;
                `SEL_DIRECTION: read_value = dirs;
                default:        read_value = 8'h00;
            endcase
        end
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // The bus lines idle high, so their filters start high to keep
    // reset from looking like a Start or a Stop.
    pin_sync #(
        .WIDTH (2),
        .INIT  (2'h3)
    ) u_bus_sync (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .pin_raw   ({scl_in, sda_in}),
        .pin_level (bus_level)
    );

    pin_sync #(
        .WIDTH (11),
        .INIT  (11'h000)
    ) u_pin_sync (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .pin_raw   ({addr_select_bit2, addr_select_bit1, addr_select_bit0, port_in}),
        .pin_level (pin_level)
    );

    assign scl_s     = bus_level[1];
    assign sda_s     = bus_level[0];
    assign port_s    = pin_level[7:0];
    assign addr_pins = pin_level[10:8];

    // ****************************************************************
    // Bus events
    // ****************************************************************
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    assign scl_rise   = scl_s & ~scl_q;
    assign scl_fall   = ~scl_s & scl_q;
    assign start_seen = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_seen  = scl_s & scl_q & ~sda_q & sda_s;
    assign addr_match = (rx_shift[7:1] == {`ADDR_UPPER, addr_pins});

    // ****************************************************************
    // Slave transaction engine
    // ****************************************************************
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state       <= ST_IDLE;
            bit_count   <= 4'h0;
            rx_shift    <= 8'h00;
            tx_shift    <= 8'h00;
            read_mode   <= 1'b0;
            addressed   <= 1'b0;
            master_ack  <= 1'b0;
            sda_oe      <= 1'b0;
            reg_select  <= `RST_SELECT;
            port_out    <= `RST_OUTPUT;
            polarity    <= `RST_POLARITY;
            port_oe     <= ~`RST_DIRECTION;
            alert_clear <= 1'b0;
        end
        else
        begin
            alert_clear <= 1'b0;
            if (stop_seen)
            begin
                // Only a transaction that addressed us may clear the alert.
                alert_clear <= addressed;
                addressed   <= 1'b0;
                state       <= ST_IDLE;
                sda_oe      <= 1'b0;
            end
            else if (start_seen)
            begin
                // The selected register is untouched across a restart.
                state     <= ST_ADDR;
                bit_count <= 4'h0;
                sda_oe    <= 1'b0;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        sda_oe <= 1'b0;
                    end
                    ST_ADDR, ST_CMD, ST_WDATA:
                    begin
                        if (scl_rise)
                        begin
                            rx_shift  <= {rx_shift[6:0], sda_s};
                            bit_count <= bit_count + 4'h1;
                        end
                        else if (scl_fall && bit_count == `BYTE_BITS)
                        begin
                            bit_count <= 4'h0;
                            if (state == ST_ADDR)
                            begin
                                if (addr_match)
                                begin
                                    addressed <= 1'b1;
                                    read_mode <= rx_shift[0];
                                    sda_oe    <= 1'b1;
                                    state     <= ST_ADDR_ACK;
                                end
                                else
                                begin
                                    state <= ST_IDLE;
                                end
                            end
                            else if (state == ST_CMD)
                            begin
                                reg_select <= rx_shift[1:0];
                                sda_oe     <= 1'b1;
                                state      <= ST_CMD_ACK;
                            end
                            else
                            begin
                                case (reg_select)
                                    `SEL_OUTPUT:    port_out <= rx_shift;
                                    `SEL_POLARITY:  polarity <= rx_shift;
                                    `SEL_DIRECTION: port_oe  <= ~rx_shift;
                                    default:        port_out <= port_out;
                                endcase
                                sda_oe <= 1'b1;
                                state  <= ST_WDATA_ACK;
                            end
                        end
                    end
                    ST_ADDR_ACK:
                    begin
                        if (scl_rise && read_mode)
                        begin
                            tx_shift <= read_value(reg_select, port_s, port_out, polarity, ~port_oe);
                        end
                        else if (scl_fall)
                        begin
                            if (read_mode)
                            begin
                                sda_oe <= ~tx_shift[7];
                                state  <= ST_RDATA;
                            end
                            else
                            begin
                                sda_oe <= 1'b0;
                                state  <= ST_CMD;
                            end
                        end
                    end
                    ST_CMD_ACK, ST_WDATA_ACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_oe <= 1'b0;
                            state  <= ST_WDATA;
                        end
                    end
                    ST_RDATA:
                    begin
                        if (scl_rise)
                        begin
                            bit_count <= bit_count + 4'h1;
                        end
                        else if (scl_fall)
                        begin
                            if (bit_count == `BYTE_BITS)
                            begin
                                bit_count <= 4'h0;
                                sda_oe    <= 1'b0;
                                state     <= ST_RDATA_ACK;
                            end
                            else
                            begin
                                tx_shift <= {tx_shift[6:0], 1'b0};
                                sda_oe   <= ~tx_shift[6];
                            end
                        end
                    end
                    ST_RDATA_ACK:
                    begin
                        if (scl_rise)
                        begin
                            master_ack  <= ~sda_s;
                            // Fresh sample for the next byte, and the clear acts
                            // on ACK and NACK alike; a pin change in the next
                            // cycle is taken into the snapshot and not alerted.
                            tx_shift    <= read_value(reg_select, port_s, port_out, polarity, ~port_oe);
                            alert_clear <= (reg_select == `SEL_INPUT);
                        end
                        else if (scl_fall)
                        begin
                            if (master_ack)
                            begin
                                sda_oe <= ~tx_shift[7];
                                state  <= ST_RDATA;
                            end
                            else
                            begin
                                // After a NACK the line stays released for the Stop.
                                state <= ST_IDLE;
                            end
                        end
                    end
                    default:
                    begin
                        state  <= ST_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign sda_out = 1'b0;

    // ****************************************************************
    // Alert
    // ****************************************************************
    alert_logic u_alert (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .port_level (port_s),
        .input_mode (~port_oe),
        .clear_req  (alert_clear),
        .alert      (alert)
    );

    // The pin is only ever pulled low or left to the pull-up.
    assign alert_n_out = 1'b0;
    assign alert_n_oe  = alert;

endmodule

// file: tb/port_expander_chk.sv
// Checker for the port expander's bus, register and alert behaviour.
module port_expander_chk (
    // Clock and reset
    input wire       core_clk,
    input wire       sys_rst,
    // Serial bus
    input wire       scl_in,
    input wire       sda_in,
    input wire       sda_out,
    input wire       sda_oe,
    // Address select pins
    input wire       addr_select_bit0,
    input wire       addr_select_bit1,
    input wire       addr_select_bit2,
    // Port pins and alert
    input wire [7:0] port_in,
    input wire [7:0] port_out,
    input wire [7:0] port_oe,
    input wire       alert_n_out,
    input wire       alert_n_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       sda_q;
    logic       hit;
    wire        stop_seen = scl_in && sda_in && !sda_q;
    wire  [7:0] in_mask   = port_in & ~port_oe;

    // ********
    // Addressed since the last Stop
    // ********
    // The slave only pulls data when addressed, so its first drive marks the transaction as ours.
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            sda_q <= 1'b1;
            hit   <= 1'b0;
        end
        else
        begin
            sda_q <= sda_in;
            if (stop_seen)
                hit <= 1'b0;
            else if (sda_oe)
                hit <= 1'b1;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    reset_values_a: assert property (
        $fell(sys_rst) |-> port_out == 8'hff && port_oe == 8'h00 && !alert_n_oe)
        else $error("reset values wrong");
    alert_drive_a: assert property (alert_n_out == 1'b0)
        else $error("alert pin drives high");
    sda_drive_a: assert property (sda_out == 1'b0)
        else $error("data pin drives high");
    sda_timing_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data changed while clock high");
    reg_update_a: assert property ($changed(port_out) || $changed(port_oe) |-> !scl_in)
        else $error("register changed while clock high");
    change_alert_a: assert property (
        (!alert_n_oe && $changed(in_mask) && $stable(port_oe)) ##1 $stable(in_mask) [*6]
        |-> ##[0:3] alert_n_oe)
        else $error("input change without alert");
    quiet_inputs_a: assert property (
        (!alert_n_oe && $stable(in_mask) && $stable(port_oe)) [*8] |=> !alert_n_oe)
        else $error("alert without input change");
    stop_clear_a: assert property (
        stop_seen && hit |-> ##[1:12] !alert_n_oe)
        else $error("alert kept after Stop");
    foreign_stop_a: assert property (
        (stop_seen && !hit && alert_n_oe) ##1 $stable(in_mask) [*8] |-> alert_n_oe)
        else $error("alert cleared by other traffic");
endmodule

// file: tb/bus_master.sv
// Serial bus master model: Start, Stop and byte transfers on an open-drain bus.
module bus_master (
    // Bus lines
    output logic scl,
    output logic sda_pull,
    input  wire  sda
);
    timeunit 1ns;
    timeprecision 1ns;
    // Phases of four core cycles leave the slave's synchroniser room in each half.
    localparam int Q = 200;

    initial
    begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // The odd offset keeps bus edges away from core clock edges.
    task automatic start();
        sda_pull = 1'b0;
        #(2*Q+13) scl = 1'b1;
        #Q sda_pull = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask

    // Data rises while the clock is high, then both lines rest released.
    task automatic stop();
        sda_pull = 1'b1;
        #Q scl = 1'b1;
        #Q sda_pull = 1'b0;
        #(3*Q);
    endtask

    task automatic bit_io(input logic b, output logic r);
        sda_pull = ~b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
        #Q;
    endtask

    // Byte out with the most significant bit first, then the slave's answer.
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // Byte in; acknowledge is withheld after the last wanted byte.
    task automatic recv(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~ack, r);
    endtask
endmodule

// file: tb/port_expander_tb.sv
// Testbench for the port expander: bus transfers, registers and alert.
module port_expander_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [6:0] DEV = 7'h25;
    logic       core_clk;
    logic       sys_rst;
    logic       scl;
    logic       sda_pull;
    wire        sda;
    wire        sda_out;
    wire        sda_oe;
    logic [2:0] addr_pins;
    logic [7:0] ext;
    wire  [7:0] port_in;
    wire  [7:0] port_out;
    wire  [7:0] port_oe;
    wire        alert_n_out;
    wire        alert_n_oe;
    wire        alert_line;
    logic       ack;
    logic [7:0] rd;
    int         n_checks;
    int         n_mismatch;

    // Open-drain lines with pull-ups; driven port pins follow the output register.
    assign sda        = ~(sda_pull | (sda_oe & ~sda_out));
    assign alert_line = ~(alert_n_oe & ~alert_n_out);
    assign port_in    = (port_oe & port_out) | (~port_oe & ext);

    port_expander i_port_expander (
        .core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_bit0(addr_pins[0]),
        .addr_select_bit1(addr_pins[1]), .addr_select_bit2(addr_pins[2]),
        .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
        .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe)
    );
    bus_master i_bus_master (.scl(scl), .sda_pull(sda_pull), .sda(sda));

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic alert_is(input logic v);
        check({7'h0, alert_line}, {7'h0, v});
    endtask

    // A pin change needs the synchroniser and the alert logic behind it before a look.
    task automatic pins(input logic [7:0] v);
        @(posedge core_clk);
        ext <= v;
        repeat (12) @(posedge core_clk);
    endtask

    task automatic head(input logic [6:0] a, input logic [7:0] c);
        i_bus_master.start();
        i_bus_master.send({a, 1'b0}, ack);
        i_bus_master.send(c, ack);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d);
        head(a, c);
        i_bus_master.send(d, ack);
        i_bus_master.stop();
        check({7'h0, ack}, {7'h0, a == DEV});
    endtask

    task automatic rdreg(input logic [7:0] c, input logic [7:0] exp);
        head(DEV, c);
        i_bus_master.start();
        i_bus_master.send({DEV, 1'b1}, ack);
        i_bus_master.recv(1'b1, rd);
        check(rd, exp);
        i_bus_master.recv(1'b0, rd);
        check(rd, exp);
        i_bus_master.stop();
    endtask

    initial
    begin
        sys_rst    = 1'b1;
        ext        = 8'h0a;
        addr_pins  = 3'b101;
        n_checks   = 0;
        n_mismatch = 0;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (12) @(posedge core_clk);
        check(port_out, 8'hff);
        check({port_oe[6:0], sda_oe}, 8'h00);
        alert_is(1'b1);
        rdreg(8'hfd, 8'hff);
        rdreg(8'h02, 8'h00);
        rdreg(8'h03, 8'hff);
        rdreg(8'h00, 8'h0a);
        wr(DEV, 8'h03, 8'h0f);
        check(port_oe, 8'hf0);
        head(DEV, 8'h01);
        i_bus_master.send(8'h3c, ack);
        i_bus_master.send(8'h99, ack);
        i_bus_master.stop();
        check(port_out, 8'h99);
        check({7'h0, ack}, 8'h01);
        alert_is(1'b1);
        wr(DEV, 8'h02, 8'h03);
        rdreg(8'h00, {4'h9, ext[3:0]} ^ 8'h03);
        rdreg(8'h01, 8'h99);
        rdreg(8'h02, 8'h03);
        rdreg(8'h03, 8'h0f);
        pins(8'h0b);
        alert_is(1'b0);
        pins(8'h0a);
        alert_is(1'b1);
        pins(8'h8a);
        alert_is(1'b1);
        pins(8'h0e);
        alert_is(1'b0);
        wr(7'h20, 8'h01, 8'h00);
        alert_is(1'b0);
        check(port_out, 8'h99);
        head(DEV, 8'h00);
        i_bus_master.start();
        i_bus_master.send({DEV, 1'b1}, ack);
        i_bus_master.recv(1'b1, rd);
        check(rd, 8'h9d);
        alert_is(1'b1);
        pins(8'h0c);
        alert_is(1'b0);
        i_bus_master.recv(1'b1, rd);
        check(rd, 8'h9d);
        alert_is(1'b1);
        i_bus_master.recv(1'b0, rd);
        check(rd, 8'h9f);
        i_bus_master.stop();
        pins(8'h0d);
        alert_is(1'b0);
        wr(DEV, 8'h02, 8'h03);
        alert_is(1'b1);
        head(DEV, 8'h01);
        repeat (3) i_bus_master.bit_io(1'b0, rd[0]);
        i_bus_master.stop();
        check(port_out, 8'h99);
        wr(DEV, 8'h01, 8'h66);
        check(port_out, 8'h66);
        alert_is(1'b1);
        wr(DEV, 8'h04, 8'h55);
        check(port_out, 8'h66);
        check(port_oe, 8'hf0);
        results();
    end

    initial
    begin
        #2_000_000;
        n_mismatch++;
        results();
    end
endmodule

bind port_expander port_expander_chk i_port_expander_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_bit0(addr_select_bit0),
    .addr_select_bit1(addr_select_bit1), .addr_select_bit2(addr_select_bit2),
    .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
    .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe)
);
